// ==== osd_pkg.sv ====
// Constants, types and step table for the orientation status and debounce block
package osd_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 10;
  localparam int INC_W  = 9;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_DEBOUNCE = 8'h12;

  // Status fields
  localparam int ST_FLAG_BIT  = 7;
  localparam int ST_ZTILT_BIT = 6;
  localparam int ST_QUAD_MSB  = 2;
  localparam int ST_QUAD_LSB  = 1;
  localparam int ST_FACE_BIT  = 0;

  // Config fields
  localparam int CFG_MODE_BIT = 7;
  localparam int CFG_EN_BIT   = 6;

  // Reset values
  localparam logic [DATA_W-1:0] STATUS_RST   = 8'h00;
  localparam logic [DATA_W-1:0] CONFIG_RST   = 8'h80;
  localparam logic [DATA_W-1:0] DEBOUNCE_RST = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL = 8'h00;

  typedef enum logic [1:0] {
    QUAD_PORTRAIT_UP   = 2'b00,
    QUAD_PORTRAIT_DOWN = 2'b01,
    QUAD_LANDSCAPE_R   = 2'b10,
    QUAD_LANDSCAPE_L   = 2'b11
  } osd_quad_t;

  typedef enum logic [2:0] {
    ODR_800  = 3'b000,
    ODR_400  = 3'b001,
    ODR_200  = 3'b010,
    ODR_100  = 3'b011,
    ODR_50   = 3'b100,
    ODR_12P5 = 3'b101,
    ODR_6P25 = 3'b110,
    ODR_1P56 = 3'b111
  } osd_odr_t;

  typedef enum logic [1:0] {
    PM_NORMAL              = 2'b00,
    PM_LOW_POWER_LOW_NOISE = 2'b01,
    PM_HIGH_RES            = 2'b10,
    PM_LOW_POWER           = 2'b11
  } osd_pmode_t;

  // Sample period per rate code, in microseconds
  localparam int ODR_PERIOD_US [8] = '{1250, 2500, 5000, 10000, 20000, 80000, 160000, 640000};

  // Debounce step per rate code and power mode, in microseconds
  localparam int STEP_NORMAL_US [8] = '{1250, 2500, 5000, 10000, 20000, 20000, 20000, 20000};
  localparam int STEP_LNOISE_US [8] = '{1250, 2500, 5000, 10000, 20000, 80000, 80000, 80000};
  localparam int STEP_HIRES_US  [8] = '{1250, 2500, 2500, 2500, 2500, 2500, 2500, 2500};
  localparam int STEP_LOWPWR_US [8] = '{1250, 2500, 5000, 10000, 20000, 80000, 160000, 160000};

  // Debounce steps that elapse in one sample
  function automatic logic [INC_W-1:0] osd_step_incr(input logic [2:0] odr,
                                                     input logic [1:0] pm);
    int step_us;
    step_us = STEP_NORMAL_US[odr];
    case (pm)
      PM_LOW_POWER_LOW_NOISE: step_us = STEP_LNOISE_US[odr];
      PM_HIGH_RES:            step_us = STEP_HIRES_US[odr];
      PM_LOW_POWER:           step_us = STEP_LOWPWR_US[odr];
      default:                step_us = STEP_NORMAL_US[odr];
    endcase
    return INC_W'(ODR_PERIOD_US[odr] / step_us);
  endfunction

endpackage

// ==== osd_debounce.sv ====
// Debounce step counter for orientation changes
`timescale 1ns/10ps
`default_nettype none
module osd_debounce (
  // Clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset,
  input  wire logic                        i_clk_en,
  // Control
  input  wire logic                        i_restart,
  input  wire logic                        i_sample,
  input  wire logic                        i_valid,
  input  wire logic                        i_clear_mode,
  input  wire logic [osd_pkg::INC_W-1:0]   i_inc,
  input  wire logic [osd_pkg::DATA_W-1:0]  i_target,
  // Result
  output logic                             o_reached,
  output logic      [osd_pkg::CNT_W-1:0]   o_count
);
  import osd_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] sum_w;
  logic [CNT_W-1:0] inc_w;
  logic [CNT_W-1:0] dec_w;

  assign inc_w = CNT_W'(i_inc);
  assign sum_w = cnt_q + inc_w;
  assign dec_w = (cnt_q > inc_w) ? (cnt_q - inc_w) : '0;
  assign o_reached = i_sample & i_valid & (sum_w >= CNT_W'(i_target));

  assign cnt_d = i_restart ? '0 :
                 !i_sample ? cnt_q :
                 i_valid   ? (o_reached ? '0 : sum_w) :
                 i_clear_mode ? '0 : dec_w;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else if (i_clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  assign o_count = cnt_q;

endmodule
`default_nettype wire

// ==== osd_orient_status.sv ====
// Orientation status, configuration and debounce registers
`timescale 1ns/10ps
`default_nettype none
// Function
// - Change flag bit 7 sets on first detection after activation and result changes.
// - A status register read clears the change flag and its interrupt, except when an update sets it in the same cycle.
// - Orientation fields keep following results while the flag is still set.
// - Result frozen while any axis magnitude exceeds 1.25 g.
// - Quadrant bits 2:1: portrait up 00, down 01, landscape right 10, left 11.
// - Face bit 0 reads 0 for front, 1 for back.
// - Bit 6 reads 1 once Z-tilt lockout tripped, else 0.
// - After power-up fields read front, portrait up and no lockout until a detection.
// - Mode 0 decrements counter when condition invalid; mode 1, reset value, clears.
// - Detection runs only while enable bit 6 is 1; resets to 0.
// - 8-bit count sets debounce steps a new orientation must persist.
// - Minimum latency is count times a rate-derived time step.
// - Rate change or active/standby transition resets debounce counters.
// - Normal mode step 1.25 ms at 800 Hz, doubling, 20 ms at 50 Hz and below.
module osd_orient_status (
  // Clock, reset, enable
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset,
  input  wire logic                        i_clk_en,
  // Register port
  input  wire logic [osd_pkg::ADDR_W-1:0]  i_reg_addr,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [osd_pkg::DATA_W-1:0]  i_reg_wdata,
  output logic      [osd_pkg::DATA_W-1:0]  o_reg_rdata,
  // Sensor state
  input  wire logic                        i_active,
  input  wire logic [2:0]                  i_odr,
  input  wire logic [1:0]                  i_power_mode,
  input  wire logic                        i_sample,
  input  wire logic                        i_over_range,
  // Raw orientation results
  input  wire logic [1:0]                  i_raw_quadrant,
  input  wire logic                        i_raw_face_side,
  input  wire logic                        i_raw_z_tilt,
  // Event
  output logic                             o_orient_event
);
  import osd_pkg::*;

  function automatic logic osd_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] target);
    return addr == target;
  endfunction

  logic              flag_q;
  logic              flag_d;
  logic              ztilt_q;
  osd_quad_t         quad_q;
  logic              face_q;
  logic              mode_q;
  logic              en_q;
  logic [DATA_W-1:0] dbnce_q;
  logic [2:0]        odr_q;
  logic              active_q;
  logic              first_q;
  logic [DATA_W-1:0] rdata_q;
  logic [3:0]        cand_w;
  logic [3:0]        rep_w;
  logic              restart_w;
  logic              go_w;
  logic              valid_w;
  logic              update_w;
  logic              rd_status_w;
  logic              wr_config_w;
  logic              wr_dbnce_w;
  logic [DATA_W-1:0] status_w;
  logic [DATA_W-1:0] config_w;
  logic [DATA_W-1:0] rd_mux_w;
  logic [INC_W-1:0]  inc_w;
  logic [CNT_W-1:0]  count_w;

  // Register decode
  assign rd_status_w = i_reg_rd & osd_hit(i_reg_addr, ADDR_STATUS);
  assign wr_config_w = i_reg_wr & osd_hit(i_reg_addr, ADDR_CONFIG);
  assign wr_dbnce_w  = i_reg_wr & osd_hit(i_reg_addr, ADDR_DEBOUNCE);

  always_comb begin
    status_w = STATUS_RST;
    status_w[ST_FLAG_BIT] = flag_q;
    status_w[ST_ZTILT_BIT] = ztilt_q;
    status_w[ST_QUAD_MSB:ST_QUAD_LSB] = quad_q;
    status_w[ST_FACE_BIT] = face_q;
    config_w = UNMAPPED_VAL;
    config_w[CFG_MODE_BIT] = mode_q;
    config_w[CFG_EN_BIT] = en_q;
  end

  assign rd_mux_w = osd_hit(i_reg_addr, ADDR_STATUS)   ? status_w :
                    osd_hit(i_reg_addr, ADDR_CONFIG)   ? config_w :
                    osd_hit(i_reg_addr, ADDR_DEBOUNCE) ? dbnce_q  : UNMAPPED_VAL;

  // Candidate versus reported result
  assign cand_w = {i_raw_z_tilt, i_raw_quadrant, i_raw_face_side};
  assign rep_w  = {ztilt_q, quad_q, face_q};
  // Restart on rate change or active/standby transition
  assign restart_w = (i_odr != odr_q) | (i_active != active_q);
  assign go_w = i_sample & i_active & en_q & ~i_over_range & ~restart_w;
  assign valid_w = first_q | (cand_w != rep_w);
  assign inc_w = osd_step_incr(i_odr, i_power_mode);

  osd_debounce u_debounce (
    .i_clk_sys    (i_clk_sys),
    .i_reset      (i_reset),
    .i_clk_en     (i_clk_en),
    .i_restart    (restart_w),
    .i_sample     (go_w),
    .i_valid      (valid_w),
    .i_clear_mode (mode_q),
    .i_inc        (inc_w),
    .i_target     (dbnce_q),
    .o_reached    (update_w),
    .o_count      (count_w)
  );

  assign flag_d = update_w ? 1'b1 : (rd_status_w ? 1'b0 : flag_q);

  // Registers and status
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      flag_q   <= STATUS_RST[ST_FLAG_BIT];
      ztilt_q  <= STATUS_RST[ST_ZTILT_BIT];
      quad_q   <= QUAD_PORTRAIT_UP;
      face_q   <= STATUS_RST[ST_FACE_BIT];
      mode_q   <= CONFIG_RST[CFG_MODE_BIT];
      en_q     <= CONFIG_RST[CFG_EN_BIT];
      dbnce_q  <= DEBOUNCE_RST;
      odr_q    <= ODR_800;
      active_q <= 1'b0;
      first_q  <= 1'b0;
      rdata_q  <= UNMAPPED_VAL;
    end else if (i_clk_en) begin
      flag_q   <= flag_d;
      odr_q    <= i_odr;
      active_q <= i_active;
      if (i_active & ~active_q) begin
        first_q <= 1'b1;
      end else if (update_w) begin
        first_q <= 1'b0;
      end
      if (update_w) begin
        ztilt_q <= i_raw_z_tilt;
        quad_q  <= osd_quad_t'(i_raw_quadrant);
        face_q  <= i_raw_face_side;
      end
      if (wr_config_w) begin
        mode_q <= i_reg_wdata[CFG_MODE_BIT];
        en_q   <= i_reg_wdata[CFG_EN_BIT];
      end
      if (wr_dbnce_w) begin
        dbnce_q <= i_reg_wdata;
      end
      if (i_reg_rd) begin
        rdata_q <= rd_mux_w;
      end
    end
  end

  assign o_reg_rdata    = rdata_q;
  assign o_orient_event = flag_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  AST_FLAG_SET: assert property (
    i_clk_en && update_w |=> flag_q && o_orient_event)
    else $error("change flag not set after update");

  AST_READ_CLEAR: assert property (
    i_clk_en && rd_status_w && !update_w |=> !flag_q ##0 o_reg_rdata[ST_FLAG_BIT] == $past(flag_q))
    else $error("status read did not clear flag");

  AST_FIELDS_FOLLOW: assert property (
    i_clk_en && update_w && flag_q |=> rep_w == $past(cand_w))
    else $error("fields did not follow while flag set");

  AST_FREEZE: assert property (
    i_over_range |-> !update_w ##1 $stable(rep_w))
    else $error("result changed during over range");

  AST_QUAD_CODE: assert property (
    i_clk_en && update_w |=> status_w[ST_QUAD_MSB:ST_QUAD_LSB] == $past(i_raw_quadrant))
    else $error("quadrant code mismatch");

  AST_FACE_BIT: assert property (
    i_clk_en && update_w |=> status_w[ST_FACE_BIT] == $past(i_raw_face_side))
    else $error("face bit mismatch");

  AST_ZTILT_BIT: assert property (
    i_clk_en && update_w |=> status_w[ST_ZTILT_BIT] == $past(i_raw_z_tilt))
    else $error("z tilt bit mismatch");

  AST_POWERUP: assert property (
    $past(i_reset) |-> status_w == STATUS_RST && config_w == CONFIG_RST)
    else $error("registers not at reset values");

  AST_CLEAR_MODE: assert property (
    i_clk_en && go_w && !valid_w && mode_q |=> count_w == '0)
    else $error("counter not cleared in clear mode");

  AST_DEC_MODE: assert property (
    i_clk_en && go_w && !valid_w && !mode_q && count_w > CNT_W'(inc_w)
    |=> count_w == $past(count_w) - CNT_W'($past(inc_w)))
    else $error("counter not decremented");

  AST_ENABLE: assert property (
    !en_q |-> !update_w)
    else $error("detection ran while disabled");

  AST_COUNT_REACHED: assert property (
    update_w |-> count_w + CNT_W'(inc_w) >= CNT_W'(dbnce_q))
    else $error("update before count reached");

  AST_RESTART: assert property (
    i_clk_en && restart_w |-> !update_w ##1 count_w == '0)
    else $error("counter not reset on rate or mode change");

  AST_STEP_800: assert property (
    i_odr == ODR_800 |-> inc_w == INC_W'(1))
    else $error("step at top rate wrong");

  AST_ONE_PER_SAMPLE: assert property (
    !(i_clk_en && update_w) |=> $stable(rep_w))
    else $error("fields changed without update");

  AST_CLK_EN_FREEZE: assert property (
    !i_clk_en |=> $stable(flag_q) && $stable(count_w) && $stable(o_reg_rdata) && $stable(dbnce_q))
    else $error("state changed while clock enable low");

endmodule
`default_nettype wire

// ==== test_orientation_status_debounce.sv ====
// Self-checking testbench for the orientation status and debounce block
`timescale 1ns/10ps
`default_nettype none
module test_orientation_status_debounce;
  import osd_pkg::*;
  logic              i_clk_sys = 1'b0;
  logic              i_reset   = 1'b1;
  logic [ADDR_W-1:0] addr      = 8'h00;
  logic              wr        = 1'b0;
  logic              rd        = 1'b0;
  logic [DATA_W-1:0] wdata     = 8'h00;
  logic [DATA_W-1:0] rdata;
  logic              active    = 1'b0;
  logic [2:0]        odr       = 3'h0;
  logic              smp       = 1'b0;
  logic              ovr       = 1'b0;
  logic [1:0]        quad      = 2'h0;
  logic              face      = 1'b0;
  logic              tilt      = 1'b0;
  logic              evt;
  logic              clk_en    = 1'b1;
  logic [1:0]        pmode     = 2'h0;
  int                num_errors  = 0;
  int                check_count = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  osd_orient_status dut (
    .i_clk_sys       (i_clk_sys),
    .i_reset         (i_reset),
    .i_clk_en        (clk_en),
    .i_reg_addr      (addr),
    .i_reg_wr        (wr),
    .i_reg_rd        (rd),
    .i_reg_wdata     (wdata),
    .o_reg_rdata     (rdata),
    .i_active        (active),
    .i_odr           (odr),
    .i_power_mode    (pmode),
    .i_sample        (smp),
    .i_over_range    (ovr),
    .i_raw_quadrant  (quad),
    .i_raw_face_side (face),
    .i_raw_z_tilt    (tilt),
    .o_orient_event  (evt)
  );

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    @(negedge i_clk_sys);
    check(name, exp, rdata);
  endtask

  task automatic raw(input logic [1:0] q, input logic f, input logic t);
    @(posedge i_clk_sys);
    quad <= q;
    face <= f;
    tilt <= t;
  endtask

  task automatic run(input int n, input logic o);
    repeat (n) begin
      @(posedge i_clk_sys);
      smp <= 1'b1;
      ovr <= o;
      @(posedge i_clk_sys);
      smp <= 1'b0;
      ovr <= 1'b0;
    end
    repeat (2) @(posedge i_clk_sys);
  endtask

  task automatic ev(input logic e);
    @(negedge i_clk_sys);
    check("event", {7'h00, e}, {7'h00, evt});
  endtask

  task automatic t_regs;
    rchk("status_rst", ADDR_STATUS, 8'h00); // no lockout
    rchk("config_rst", ADDR_CONFIG, 8'h80); // reset value
    rchk("debounce_rst", ADDR_DEBOUNCE, 8'h00); // reset value
    rchk("unmapped", 8'h13, 8'h00);
    wreg(ADDR_STATUS, 8'hFF);
    rchk("status_ro", ADDR_STATUS, 8'h00); // read only
    wreg(ADDR_CONFIG, 8'hFF);
    rchk("config_mask", ADDR_CONFIG, 8'hC0); // mode and enable bits
    wreg(ADDR_DEBOUNCE, 8'hFF);
    rchk("debounce_rw", ADDR_DEBOUNCE, 8'hFF); // full field
    wreg(ADDR_CONFIG, 8'h80);
    wreg(ADDR_DEBOUNCE, 8'h00);
  endtask

  task automatic t_disabled;
    active <= 1'b1;
    raw(2'h2, 1'b1, 1'b0);
    run(4, 1'b0);
    ev(1'b0); // disabled ignores
    rchk("disabled", ADDR_STATUS, 8'h00); // no update
  endtask

  task automatic t_first;
    wreg(ADDR_DEBOUNCE, 8'h02);
    wreg(ADDR_CONFIG, 8'hC0);
    run(1, 1'b0);
    ev(1'b0); // count not reached
    run(1, 1'b0);
    ev(1'b1); // first detection
    rchk("first", ADDR_STATUS, 8'h85); // fields
    ev(1'b0); // read clears
    run(3, 1'b0);
    ev(1'b0); // no change no flag
  endtask

  task automatic t_quads;
    for (int q = 0; q < 4; q++) begin
      raw(q[1:0], q[1], q[0]);
      run(2, 1'b0);
      rchk("quad", ADDR_STATUS, {1'b1, q[0], 3'b000, q[1:0], q[1]}); // codes
    end
  endtask

  task automatic t_over;
    raw(2'h0, 1'b0, 1'b0);
    run(3, 1'b1);
    ev(1'b0); // frozen
    run(2, 1'b0);
    ev(1'b1); // released
    rchk("over", ADDR_STATUS, 8'h80); // lockout cleared
  endtask

  task automatic t_follow;
    raw(2'h1, 1'b0, 1'b0);
    run(2, 1'b0);
    ev(1'b1); // change flag
    raw(2'h1, 1'b1, 1'b1);
    run(2, 1'b0);
    rchk("follow", ADDR_STATUS, 8'hC3); // fields keep moving
  endtask

  task automatic t_modes;
    wreg(ADDR_DEBOUNCE, 8'h04);
    raw(2'h2, 1'b0, 1'b0);
    run(3, 1'b0);
    raw(2'h1, 1'b1, 1'b1);
    run(1, 1'b0);
    raw(2'h2, 1'b0, 1'b0);
    run(3, 1'b0);
    ev(1'b0); // clear mode
    run(1, 1'b0);
    ev(1'b1); // full count
    rchk("mode1", ADDR_STATUS, 8'h84); // update on reach
    wreg(ADDR_CONFIG, 8'h40);
    raw(2'h3, 1'b0, 1'b0);
    run(3, 1'b0);
    raw(2'h2, 1'b0, 1'b0);
    run(1, 1'b0);
    raw(2'h3, 1'b0, 1'b0);
    run(2, 1'b0);
    ev(1'b1); // decrement mode
    rchk("mode0", ADDR_STATUS, 8'h86); // update on reach
  endtask

  task automatic t_rate;
    wreg(ADDR_DEBOUNCE, 8'h03);
    raw(2'h0, 1'b0, 1'b0);
    run(2, 1'b0);
    odr <= 3'h1;
    run(2, 1'b0);
    ev(1'b0); // rate change resets
    run(1, 1'b0);
    ev(1'b1); // latency count
    rchk("rate", ADDR_STATUS, 8'h80); // update on reach
  endtask

  task automatic t_step;
    @(posedge i_clk_sys);
    odr <= 3'h5;
    wreg(ADDR_DEBOUNCE, 8'h08);
    raw(2'h1, 1'b0, 1'b0);
    run(1, 1'b0);
    ev(1'b0); // four steps per sample
    run(1, 1'b0);
    ev(1'b1); // 20 ms step
    rchk("step", ADDR_STATUS, 8'h82); // latency
  endtask

  task automatic t_react;
    @(posedge i_clk_sys);
    odr <= 3'h0;
    wreg(ADDR_DEBOUNCE, 8'h02);
    raw(2'h2, 1'b0, 1'b0);
    run(1, 1'b0);
    active <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    active <= 1'b1;
    run(1, 1'b0);
    ev(1'b0); // standby resets count
    run(1, 1'b0);
    ev(1'b1); // first after activation
    rchk("react", ADDR_STATUS, 8'h84); // update on reach
  endtask

  task automatic t_pmode;
    @(posedge i_clk_sys);
    odr   <= 3'h7;
    pmode <= 2'h2;
    wreg(ADDR_DEBOUNCE, 8'hFF);
    raw(2'h3, 1'b1, 1'b0);
    run(1, 1'b0);
    ev(1'b1); // high resolution step
    rchk("hires", ADDR_STATUS, 8'h87); // one sample spans count
    @(posedge i_clk_sys);
    pmode <= 2'h3;
    wreg(ADDR_DEBOUNCE, 8'h08);
    raw(2'h0, 1'b0, 1'b0);
    run(1, 1'b0);
    ev(1'b0); // low power four steps
    run(1, 1'b0);
    ev(1'b1); // low power reached
    rchk("lowpwr", ADDR_STATUS, 8'h80); // latency
    @(posedge i_clk_sys);
    pmode <= 2'h1;
    wreg(ADDR_DEBOUNCE, 8'h10);
    raw(2'h1, 1'b0, 1'b0);
    run(1, 1'b0);
    ev(1'b0); // low noise eight steps
    run(1, 1'b0);
    ev(1'b1); // low noise reached
    rchk("lownoise", ADDR_STATUS, 8'h82); // latency
  endtask

  task automatic t_clken;
    @(posedge i_clk_sys);
    clk_en <= 1'b0;
    wreg(ADDR_DEBOUNCE, 8'h55);
    rchk("frozen_rd", ADDR_CONFIG, 8'h82);
    raw(2'h2, 1'b0, 1'b0);
    run(2, 1'b0);
    ev(1'b0); // no evaluation while frozen
    @(posedge i_clk_sys);
    clk_en <= 1'b1;
    rchk("frozen_wr", ADDR_DEBOUNCE, 8'h10); // write not taken
    run(2, 1'b0);
    ev(1'b1); // count resumes from zero
  endtask

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_regs();
    t_disabled();
    t_first();
    t_quads();
    t_over();
    t_follow();
    t_modes();
    t_rate();
    t_step();
    t_react();
    t_pmode();
    t_clken();
    results();
  end

  initial begin
    #2000000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
